/* File: sensor_alarm_lane_polarity_regs.sv */
// register bank for monitors, alarm masks and lane polarity, on AXI4-Lite
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`include "salp_params.svh"
module sensor_alarm_lane_polarity_regs
    import salp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [2:0]  tempLevel,
    input  wire logic [2:0]  volt0Level,
    input  wire logic [2:0]  volt1Level,
    input  wire logic        missingFrameEvt,
    input  wire logic        phySyncFaultEvt,
    input  wire logic        phyControlFaultEvt,
    input  wire logic        headerEccEvt,
    input  wire logic        payloadCheckEvt,
    input  wire logic        lengthErrEvt,
    input  wire logic        bcCrcErrEvt,
    input  wire logic        bcLinkDetectEvt,
    output logic             monitorsOn,
    output logic             sensePin0,
    output logic             sensePin1,
    output logic [7:0]       voltageGain,
    output logic [4:0]       pnSwap,
    output logic [4:0]       lpInvert,
    output logic [5:0]       sensorFlags,
    output logic             alarmOut
);
    salp_byte_t   monCtl_r, gainCtl_r, v0Lim_r, v1Lim_r, tLim_r;
    salp_byte_t   csiMask_r, sensMask_r, bcMask_r, pnSwap_r, lpSwap_r;
    logic [6:0]   gainCode_r;
    logic [5:0]   flags_r;
    salp_wstate_t wState_r;
    logic [7:0]   awAddr_r, wData_r;
    logic         awHave_r, wHave_r;
    logic         monOn_r, pin0_r, pin1_r, alarm_r;
    logic [7:0]   gain_r;
    logic [31:0]  rData_r;
    logic         rValid_r, bValid_r;
    logic [1:0]   bResp_r, rResp_r;

    function automatic logic [5:0] word_index(input logic [7:0] addr);
        word_index = addr[7:2];
    endfunction

    function automatic logic idx_is(input logic [7:0] addr, input logic [7:0] idx);
        idx_is = ({2'h0, word_index(addr)} == idx);
    endfunction

    function automatic logic idx_mapped(input logic [7:0] addr);
        idx_mapped = (idx_is(addr, `SALP_IDX_MONCTL) || idx_is(addr, `SALP_IDX_GAINCTL)
            || idx_is(addr, `SALP_IDX_V0LIM) || idx_is(addr, `SALP_IDX_V1LIM)
            || idx_is(addr, `SALP_IDX_TLIM) || idx_is(addr, `SALP_IDX_CSIMASK)
            || idx_is(addr, `SALP_IDX_SENSMASK) || idx_is(addr, `SALP_IDX_BCMASK)
            || idx_is(addr, `SALP_IDX_SPARE) || idx_is(addr, `SALP_IDX_PNSWAP)
            || idx_is(addr, `SALP_IDX_LPSWAP) || idx_is(addr, `SALP_IDX_GAINCODE)
            || idx_is(addr, `SALP_IDX_STATUS));
    endfunction

    // write channel: address and data caught independently, committed together
    wire          awTake   = s_axi_awvalid && !awHave_r && (wState_r == SALP_IDLE);
    wire          wTake    = s_axi_wvalid && !wHave_r && (wState_r == SALP_IDLE);
    wire [7:0]    wAddrEff = awHave_r ? awAddr_r : s_axi_awaddr;
    wire [7:0]    wDataEff = wHave_r ? wData_r : s_axi_wdata[7:0];
    wire          wLane_r;
    logic         wLaneHeld_r;
    assign wLane_r = wLaneHeld_r;
    wire          wLane    = wHave_r ? wLane_r : s_axi_wstrb[0];
    wire          commit   = (wState_r == SALP_IDLE) && (awHave_r || awTake)
                             && (wHave_r || wTake);
    wire          wrOk     = idx_mapped(wAddrEff);
    wire          wrEn     = commit && wrOk && wLane;
    wire          wrMon    = wrEn && idx_is(wAddrEff, `SALP_IDX_MONCTL);
    wire          wrGainC  = wrEn && idx_is(wAddrEff, `SALP_IDX_GAINCTL);
    wire          wrV0     = wrEn && idx_is(wAddrEff, `SALP_IDX_V0LIM);
    wire          wrV1     = wrEn && idx_is(wAddrEff, `SALP_IDX_V1LIM);
    wire          wrT      = wrEn && idx_is(wAddrEff, `SALP_IDX_TLIM);
    wire          wrCsi    = wrEn && idx_is(wAddrEff, `SALP_IDX_CSIMASK);
    wire          wrSens   = wrEn && idx_is(wAddrEff, `SALP_IDX_SENSMASK);
    wire          wrBc     = wrEn && idx_is(wAddrEff, `SALP_IDX_BCMASK);
    wire          wrPn     = wrEn && idx_is(wAddrEff, `SALP_IDX_PNSWAP);
    wire          wrLp     = wrEn && idx_is(wAddrEff, `SALP_IDX_LPSWAP);
    wire          wrGain   = wrEn && idx_is(wAddrEff, `SALP_IDX_GAINCODE);
    wire          wrStat   = wrEn && idx_is(wAddrEff, `SALP_IDX_STATUS);

    // monitor decode
    wire          monOnNxt  = (monCtl_r[3:2] == `SALP_MON_ON);
    wire          pin0Nxt   = monOnNxt && monCtl_r[0];
    wire          pin1Nxt   = monOnNxt && monCtl_r[1];
    // zero code has no defined gain; it is treated as unity to avoid a divide by zero
    wire [7:0]    gainRatio = (gainCode_r == 7'h00) ? `SALP_GAIN_UNITY
                              : `SALP_GAIN_NUM / {1'b0, gainCode_r};
    wire [7:0]    gainNxt   = gainCtl_r[`SALP_BIT_GAINEN] ? gainRatio
                              : `SALP_GAIN_UNITY;

    wire          v0Over, v0Under, v1Over, v1Under, tOver, tUnder;
    salp_limit_cmp uV0
    (
        .level     (volt0Level),
        .upperCode (v0Lim_r[6:4]),
        .lowerCode (v0Lim_r[2:0]),
        .active    (pin0_r),
        .over      (v0Over),
        .under     (v0Under)
    );
    salp_limit_cmp uV1
    (
        .level     (volt1Level),
        .upperCode (v1Lim_r[6:4]),
        .lowerCode (v1Lim_r[2:0]),
        .active    (pin1_r),
        .over      (v1Over),
        .under     (v1Under)
    );
    salp_limit_cmp uT
    (
        .level     (tempLevel),
        .upperCode (tLim_r[6:4]),
        .lowerCode (tLim_r[2:0]),
        .active    (monOn_r),
        .over      (tOver),
        .under     (tUnder)
    );

    // flag order: t over, t under, volt1_high_alarm_on, volt1_low_alarm_on, volt0_high_alarm_on, volt0_low_alarm_on
    wire [5:0]    crossing  = {tOver, tUnder, v1Over, v1Under, v0Over, v0Under};
    // write-one-to-clear, but a new crossing wins over the clear
    wire [5:0]    flagsNxt  = (flags_r & ~(wrStat ? wDataEff[5:0] : 6'h00)) | crossing;
    wire          senseAlm  = |(flags_r & sensMask_r[5:0]);
    wire          csiAlm    = |({missingFrameEvt, phySyncFaultEvt, phyControlFaultEvt,
                                headerEccEvt, payloadCheckEvt, lengthErrEvt}
                                & csiMask_r[5:0]);
    wire          bcAlm     = |({bcCrcErrEvt, bcLinkDetectEvt} & bcMask_r[1:0]);

    // read decode
    wire [7:0]    rAddr   = s_axi_araddr;
    wire          rdOk    = idx_mapped(rAddr);
    wire [7:0]    rdByte  =
        idx_is(rAddr, `SALP_IDX_MONCTL)   ? monCtl_r   :
        idx_is(rAddr, `SALP_IDX_GAINCTL)  ? gainCtl_r  :
        idx_is(rAddr, `SALP_IDX_V0LIM)    ? v0Lim_r    :
        idx_is(rAddr, `SALP_IDX_V1LIM)    ? v1Lim_r    :
        idx_is(rAddr, `SALP_IDX_TLIM)     ? tLim_r     :
        idx_is(rAddr, `SALP_IDX_CSIMASK)  ? csiMask_r  :
        idx_is(rAddr, `SALP_IDX_SENSMASK) ? sensMask_r :
        idx_is(rAddr, `SALP_IDX_BCMASK)   ? bcMask_r   :
        idx_is(rAddr, `SALP_IDX_PNSWAP)   ? pnSwap_r   :
        idx_is(rAddr, `SALP_IDX_LPSWAP)   ? lpSwap_r   :
        idx_is(rAddr, `SALP_IDX_GAINCODE) ? {1'b0, gainCode_r} :
        idx_is(rAddr, `SALP_IDX_STATUS)   ? {2'h0, flags_r} : 8'h00;
    wire          arTake  = s_axi_arvalid && !rValid_r;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            awHave_r    <= 1'b0;
            wHave_r     <= 1'b0;
            awAddr_r    <= 8'h00;
            wData_r     <= 8'h00;
            wLaneHeld_r <= 1'b0;
            wState_r    <= SALP_IDLE;
            bValid_r    <= 1'b0;
            bResp_r     <= `SALP_RESP_OKAY;
        end
        else
        begin
            case (wState_r)
                SALP_IDLE:
                begin
                    if (commit)
                    begin
                        awHave_r <= 1'b0;
                        wHave_r  <= 1'b0;
                        bValid_r <= 1'b1;
                        bResp_r  <= wrOk ? `SALP_RESP_OKAY : `SALP_RESP_SLVERR;
                        wState_r <= SALP_BRESP;
                    end
                    else
                    begin
                        if (awTake)
                        begin
                            awHave_r <= 1'b1;
                            awAddr_r <= s_axi_awaddr;
                        end
                        if (wTake)
                        begin
                            wHave_r     <= 1'b1;
                            wData_r     <= s_axi_wdata[7:0];
                            wLaneHeld_r <= s_axi_wstrb[0];
                        end
                    end
                end
                SALP_BRESP:
                begin
                    if (s_axi_bready)
                    begin
                        bValid_r <= 1'b0;
                        wState_r <= SALP_IDLE;
                    end
                end
                default:
                    wState_r <= SALP_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            monCtl_r   <= `SALP_RST_MONCTL;
            gainCtl_r  <= `SALP_RST_GAINCTL;
            v0Lim_r    <= `SALP_RST_LIM;
            v1Lim_r    <= `SALP_RST_LIM;
            tLim_r     <= `SALP_RST_LIM;
            csiMask_r  <= `SALP_RST_CSIMASK;
            sensMask_r <= `SALP_RST_ZERO;
            bcMask_r   <= `SALP_RST_ZERO;
            pnSwap_r   <= `SALP_RST_ZERO;
            lpSwap_r   <= `SALP_RST_ZERO;
            gainCode_r <= `SALP_RST_GAINCODE;
            flags_r    <= 6'h00;
        end
        else
        begin
            if (wrMon)   monCtl_r   <= wDataEff;
            if (wrGainC) gainCtl_r  <= wDataEff & `SALP_MASK_GAINCTL;
            if (wrV0)    v0Lim_r    <= wDataEff & `SALP_MASK_V0LIM;
            if (wrV1)    v1Lim_r    <= wDataEff & `SALP_MASK_V0LIM;
            if (wrT)     tLim_r     <= wDataEff & `SALP_MASK_V0LIM;
            if (wrCsi)   csiMask_r  <= wDataEff & `SALP_MASK_CSI;
            if (wrSens)  sensMask_r <= wDataEff & `SALP_MASK_SENS;
            if (wrBc)    bcMask_r   <= wDataEff & `SALP_MASK_BC;
            if (wrPn)    pnSwap_r   <= wDataEff & `SALP_MASK_PN;
            if (wrLp)    lpSwap_r   <= wDataEff & `SALP_MASK_LP;
            if (wrGain)  gainCode_r <= wDataEff[6:0];
            flags_r <= flagsNxt;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rValid_r <= 1'b0;
            rData_r  <= 32'h0000_0000;
            rResp_r  <= `SALP_RESP_OKAY;
            monOn_r  <= 1'b0;
            pin0_r   <= 1'b0;
            pin1_r   <= 1'b0;
            gain_r   <= `SALP_GAIN_UNITY;
            alarm_r  <= 1'b0;
        end
        else
        begin
            if (arTake)
            begin
                rValid_r <= 1'b1;
                rData_r  <= {24'h00_0000, rdByte};
                rResp_r  <= rdOk ? `SALP_RESP_OKAY : `SALP_RESP_SLVERR;
            end
            else if (s_axi_rready)
            begin
                rValid_r <= 1'b0;
            end
            monOn_r <= monOnNxt;
            pin0_r  <= pin0Nxt;
            pin1_r  <= pin1Nxt;
            gain_r  <= gainNxt;
            alarm_r <= senseAlm | csiAlm | bcAlm;
        end
    end

    assign s_axi_awready = awTake;
    assign s_axi_wready  = wTake;
    assign s_axi_bvalid  = bValid_r;
    assign s_axi_bresp   = bResp_r;
    assign s_axi_arready = arTake;
    assign s_axi_rvalid  = rValid_r;
    assign s_axi_rdata   = rData_r;
    assign s_axi_rresp   = rResp_r;
    assign monitorsOn    = monOn_r;
    assign sensePin0     = pin0_r;
    assign sensePin1     = pin1_r;
    assign voltageGain   = gain_r;
    assign pnSwap        = pnSwap_r[4:0];
    assign lpInvert      = lpSwap_r[4:0];
    assign sensorFlags   = flags_r;
    assign alarmOut      = alarm_r;
endmodule // sensor_alarm_lane_polarity_regs

/* File: salp_params.svh */
// constants for the sensor alarm and lane polarity register bank
// How it works
// - monitor switch field 00 turns monitors off, 11 on; resets on.
// - select field picks voltage pins: none, pin0, pin1 or both.
// - programmed voltage gain applies only while gain-apply bit set; resets one.
// - pin0 sensing and level above upper code raises volt0 over alarm; code resets 6.
// - pin0 sensing and level below lower code raises volt0 under alarm; code resets 2.
// - pin1 sensing and level above upper code raises volt1 over status; resets 6.
// - pin1 sensing and level below lower code raises volt1 under status; resets 2.
// - monitor on and temperature above upper code raises temp over alarm; resets 6.
// - monitor on and temperature below lower code raises temp under alarm; resets 2.
// - missing frame-valid alarm reported only while CSI mask bit 5 is one.
// - PHY sync faults gated by bit 4, PHY control faults by bit 3; reset one.
// - header ECC bit 2, checksum bit 1, length bit 0 gate alarms; reset one.
// - temp over forwarded when sense mask bit 5 set, under with bit 4; reset zero.
// - volt1 over forwarded with sense bit 3, under with bit 2; reset zero.
// - volt0 over forwarded with sense bit 1, under with bit 0; reset zero.
// - back-channel CRC alarm gated by bit 1, link-detect by bit 0; reset zero.
// - P/N swap of clock lane by bit 4, data lanes 3..0 by bits 3..0.
// - low-power polarity invert of clock lane by bit 4, data lanes by bits 3..0.
// - voltage gain equals 128 divided by seven-bit gain code; code resets 0x20.
`ifndef SALP_PARAMS_SVH
`define SALP_PARAMS_SVH
`define SALP_IDX_MONCTL   8'h17
`define SALP_IDX_GAINCTL  8'h18
`define SALP_IDX_V0LIM    8'h19
`define SALP_IDX_V1LIM    8'h1A
`define SALP_IDX_TLIM     8'h1B
`define SALP_IDX_CSIMASK  8'h1C
`define SALP_IDX_SENSMASK 8'h1D
`define SALP_IDX_BCMASK   8'h1E
`define SALP_IDX_SPARE    8'h1F
`define SALP_IDX_PNSWAP   8'h20
`define SALP_IDX_LPSWAP   8'h21
`define SALP_IDX_GAINCODE 8'h30
`define SALP_IDX_STATUS   8'h31
`define SALP_RST_MONCTL   8'h3C
`define SALP_RST_GAINCTL  8'h80
`define SALP_RST_LIM      8'h62
`define SALP_RST_CSIMASK  8'h3F
`define SALP_RST_ZERO     8'h00
`define SALP_RST_GAINCODE 7'h20
`define SALP_MON_OFF      2'h0
`define SALP_MON_ON       2'h3
`define SALP_GAIN_NUM     8'h80
`define SALP_GAIN_UNITY   8'h01
`define SALP_MASK_PN      8'h1F
`define SALP_MASK_LP      8'h1F
`define SALP_MASK_CSI     8'h3F
`define SALP_MASK_SENS    8'h3F
`define SALP_MASK_BC      8'h03
`define SALP_MASK_V0LIM   8'h77
`define SALP_MASK_GAINCTL 8'h80
`define SALP_BIT_GAINEN   7
`define SALP_RESP_OKAY    2'h0
`define SALP_RESP_SLVERR  2'h2
`endif

/* File: salp_pkg.sv */
// types shared by the register bank
package salp_pkg;
    typedef enum logic [1:0] {SALP_IDLE, SALP_BRESP} salp_wstate_t;
    typedef logic [7:0] salp_byte_t;
endpackage

/* File: salp_limit_cmp.sv */
// window comparator for one monitored quantity
`timescale 1ns/1ps
module salp_limit_cmp
(
    input  wire logic [2:0] level,
    input  wire logic [2:0] upperCode,
    input  wire logic [2:0] lowerCode,
    input  wire logic       active,
    output logic            over,
    output logic            under
);
    assign over  = active && (level > upperCode);
    assign under = active && (level < lowerCode);
endmodule // salp_limit_cmp

/* File: salp_regs_props.sv */
// concurrent checks on the sensor alarm and lane polarity register bank ports
`timescale 1ns/1ps
module salp_regs_chk
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       missingFrameEvt,
    input  wire logic       phySyncFaultEvt,
    input  wire logic       phyControlFaultEvt,
    input  wire logic       headerEccEvt,
    input  wire logic       payloadCheckEvt,
    input  wire logic       lengthErrEvt,
    input  wire logic       bcCrcErrEvt,
    input  wire logic       bcLinkDetectEvt,
    input  wire logic       monitorsOn,
    input  wire logic       sensePin0,
    input  wire logic       sensePin1,
    input  wire logic [7:0] voltageGain,
    input  wire logic [5:0] sensorFlags,
    input  wire logic       alarmOut
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_sense_gated: assert property (sensePin0 || sensePin1 |-> monitorsOn)
        else $error("voltage sensing enabled while monitors are off");
    a_volt0_high_alarm_on_cause: assert property ($rose(sensorFlags[1]) |-> $past(sensePin0))
        else $error("volt0 over flag set without pin0 sensing");
    a_volt0_low_alarm_on_cause: assert property ($rose(sensorFlags[0]) |-> $past(sensePin0))
        else $error("volt0 under flag set without pin0 sensing");
    a_volt1_high_alarm_on_cause: assert property ($rose(sensorFlags[3]) |-> $past(sensePin1))
        else $error("volt1 over flag set without pin1 sensing");
    a_volt1_low_alarm_on_cause: assert property ($rose(sensorFlags[2]) |-> $past(sensePin1))
        else $error("volt1 under flag set without pin1 sensing");
    a_t_over_cause: assert property ($rose(sensorFlags[5]) |-> $past(monitorsOn))
        else $error("temp over flag set with monitors off");
    a_t_under_cause: assert property ($rose(sensorFlags[4]) |-> $past(monitorsOn))
        else $error("temp under flag set with monitors off");
    a_gain_nonzero: assert property (voltageGain != 8'h00)
        else $error("voltage gain reads zero");
    // alarm output lags its sources by one register stage
    a_alarm_cause: assert property ($rose(alarmOut) |-> $past((|sensorFlags) || (|{missingFrameEvt,
        phySyncFaultEvt, phyControlFaultEvt, headerEccEvt, payloadCheckEvt, lengthErrEvt,
        bcCrcErrEvt, bcLinkDetectEvt}))) else $error("alarm raised without any source");
endmodule // salp_regs_chk

bind sensor_alarm_lane_polarity_regs salp_regs_chk chk (.clk(clk), .rst(rst),
    .missingFrameEvt(missingFrameEvt), .phySyncFaultEvt(phySyncFaultEvt),
    .phyControlFaultEvt(phyControlFaultEvt), .headerEccEvt(headerEccEvt),
    .payloadCheckEvt(payloadCheckEvt), .lengthErrEvt(lengthErrEvt), .bcCrcErrEvt(bcCrcErrEvt),
    .bcLinkDetectEvt(bcLinkDetectEvt), .monitorsOn(monitorsOn), .sensePin0(sensePin0),
    .sensePin1(sensePin1), .voltageGain(voltageGain), .sensorFlags(sensorFlags),
    .alarmOut(alarmOut));

/* File: tb_top.sv */
// self-checking bench for the sensor alarm and lane polarity register bank
`timescale 1ns/1ps
`include "salp_params.svh"
module tb_top;
    import salp_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  awAddr = 8'h00, arAddr = 8'h00, ev = 8'h00;
    logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
    logic [31:0] wData = 32'h0, rData, d;
    logic [3:0]  wStrb = 4'h0;
    logic [2:0]  tLvl = 3'h4, v0Lvl = 3'h4, v1Lvl = 3'h4;
    logic        awReady, wReady, bValid, arReady, rValid, monitorsOn, sensePin0, sensePin1;
    logic        alarmOut;
    logic [1:0]  bResp, rResp, resp;
    logic [7:0]  voltageGain;
    logic [4:0]  pnSwap, lpInvert;
    logic [5:0]  sensorFlags;
    int          failures = 0, n_checks = 0, seed = 46, v;
    int          rstV[11] = '{8'h3C, 8'h80, 8'h62, 8'h62, 8'h62, 8'h3F, 0, 0, 0, 0, 0};
    int          msk[11] = '{8'hFF, 8'h80, 8'h77, 8'h77, 8'h77, 8'h3F, 8'h3F, 8'h03, 0, 8'h1F, 8'h1F};
    int          mdl[11];

    always #5 clk = ~clk;

    sensor_alarm_lane_polarity_regs DUT (.clk(clk), .rst(rst), .s_axi_awaddr(awAddr),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(rReady), .tempLevel(tLvl), .volt0Level(v0Lvl), .volt1Level(v1Lvl),
        .missingFrameEvt(ev[5]), .phySyncFaultEvt(ev[4]), .phyControlFaultEvt(ev[3]),
        .headerEccEvt(ev[2]), .payloadCheckEvt(ev[1]), .lengthErrEvt(ev[0]),
        .bcCrcErrEvt(ev[7]), .bcLinkDetectEvt(ev[6]), .monitorsOn(monitorsOn),
        .sensePin0(sensePin0), .sensePin1(sensePin1), .voltageGain(voltageGain), .pnSwap(pnSwap),
        .lpInvert(lpInvert), .sensorFlags(sensorFlags), .alarmOut(alarmOut));

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e)
        begin
            failures++;
            $display("MISMATCH %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // registers sit at four times their index
    task automatic wr(input logic [7:0] idx, input logic [7:0] dv);
        logic aOk, wOk;
        aOk = 1'b0;
        wOk = 1'b0;
        @(posedge clk);
        awAddr <= idx << 2;
        wData <= {24'h0, dv};
        wStrb <= 4'hF;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        while (!(aOk && wOk))
        begin
            @(posedge clk);
            aOk |= awReady;
            wOk |= wReady;
            awValid <= awValid & ~awReady;
            wValid <= wValid & ~wReady;
        end
        do @(posedge clk); while (!bValid);
        resp = bResp;
        bReady <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] idx);
        @(posedge clk);
        arAddr <= idx << 2;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do
        begin
            @(posedge clk);
            arValid <= arValid & ~arReady;
        end while (!rValid);
        d = rData;
        resp = rResp;
        rReady <= 1'b0;
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
    endtask

    task automatic lv(input logic [2:0] t, input logic [2:0] a, input logic [2:0] b);
        @(posedge clk);
        tLvl <= t;
        v0Lvl <= a;
        v1Lvl <= b;
    endtask

    task automatic reset_dut();
        rst <= 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask

    initial
    begin
        #300000;
        failures++;
        close_out();
    end

    initial
    begin
        reset_dut();
        for (int i = 0; i < 11; i++)
        begin
            rd(8'h17 + i);
            chk(d, rstV[i]);
            mdl[i] = rstV[i];
        end
        rd(8'h08);
        chk(resp, `SALP_RESP_SLVERR);
        wr(8'h08, 8'h5A);
        chk(resp, `SALP_RESP_SLVERR);
        for (int k = 0; k < 3; k++)
            for (int i = 0; i < 11; i++)
            begin
                v = $random(seed);
                wr(8'h17 + i, v[7:0]);
                mdl[i] = v & msk[i];
            end
        for (int i = 0; i < 11; i++)
        begin
            rd(8'h17 + i);
            chk(d, mdl[i]);
        end
        settle();
        chk(pnSwap, mdl[9][4:0]);
        chk(lpInvert, mdl[10][4:0]);
        $display("test registers done");
        for (int s = 0; s < 4; s++)
        begin
            wr(8'h17, 8'h0C | s);
            settle();
            chk({monitorsOn, sensePin1, sensePin0}, 3'b100 | s);
        end
        wr(8'h17, 8'h00);
        settle();
        chk({monitorsOn, sensePin0}, 2'b00);
        $display("test monitor switch done");
        reset_dut();
        settle();
        chk(voltageGain, 8'h04);
        wr(8'h18, 8'h00);
        settle();
        chk(voltageGain, 8'h01);
        wr(8'h18, 8'h80);
        settle();
        chk(voltageGain, 8'h04);
        wr(`SALP_IDX_GAINCODE, 8'h10);
        settle();
        chk(voltageGain, 8'h08);
        rd(`SALP_IDX_GAINCODE);
        chk(d, 32'h10);
        $display("test gain done");
        wr(8'h17, 8'h0F);
        lv(7, 7, 7);
        settle();
        chk(sensorFlags, 6'b101010);
        chk(alarmOut, 1'b0);
        lv(6, 2, 2);
        settle();
        chk(sensorFlags, 6'b101010);
        lv(0, 0, 0);
        settle();
        chk(sensorFlags, 6'h3F);
        for (int i = 0; i < 6; i++)
        begin
            wr(8'h1D, 8'h01 << i);
            settle();
            chk(alarmOut, 1'b1);
        end
        wr(8'h1D, 8'h00);
        settle();
        chk(alarmOut, 1'b0);
        lv(4, 4, 4);
        wr(`SALP_IDX_STATUS, 8'h3F);
        settle();
        chk(sensorFlags, 6'h00);
        lv(7, 4, 4);
        wr(8'h1D, 8'h10);
        settle();
        chk(sensorFlags, 6'h20);
        chk(alarmOut, 1'b0);
        wr(8'h1D, 8'h20);
        settle();
        chk(alarmOut, 1'b1);
        // a clear that meets a standing crossing must lose
        wr(`SALP_IDX_STATUS, 8'h20);
        rd(`SALP_IDX_STATUS);
        chk(d, 32'h20);
        lv(4, 4, 4);
        reset_dut();
        wr(8'h17, 8'h00);
        lv(7, 7, 7);
        settle();
        lv(0, 0, 0);
        settle();
        chk(sensorFlags, 6'h00);
        lv(4, 4, 4);
        wr(8'h17, 8'h0D);
        lv(7, 7, 7);
        settle();
        chk(sensorFlags, 6'b100010);
        lv(4, 4, 4);
        $display("test limits done");
        reset_dut();
        for (int p = 0; p < 2; p++)
        begin
            for (int i = 0; i < 8; i++)
            begin
                @(posedge clk);
                ev <= 8'h01 << i;
                settle();
                chk(alarmOut, ((p ? 8'h55 : 8'h3F) >> i) & 8'h01);
                @(posedge clk);
                ev <= 8'h00;
                settle();
            end
            wr(8'h1C, 8'h15);
            wr(8'h1E, 8'h01);
        end
        $display("test event masks done");
        close_out();
    end
endmodule // tb_top
